// >>> core/ipcl_pkg.sv
package ipcl_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int IPCL_CHANNELS  = 32;
    localparam int IPCL_IRQ_CHANS = 4;
    localparam int IPCL_ADDR_W    = 8;
    localparam int IPCL_DATA_W    = 32;
    localparam int IPCL_STRB_W    = 4;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] IPCL_M2C_SET_OFS      = 8'h00;
    localparam logic [7:0] IPCL_M2C_FLAG_SND_OFS = 8'h04;
    localparam logic [7:0] IPCL_M2C_ACK_OFS      = 8'h08;
    localparam logic [7:0] IPCL_M2C_FLAG_RCV_OFS = 8'h0C;
    localparam logic [7:0] IPCL_C2M_SET_OFS      = 8'h10;
    localparam logic [7:0] IPCL_C2M_FLAG_SND_OFS = 8'h14;
    localparam logic [7:0] IPCL_C2M_ACK_OFS      = 8'h18;
    localparam logic [7:0] IPCL_C2M_FLAG_RCV_OFS = 8'h1C;

    // ************************************************************
    // reset values and bus answers
    // ************************************************************
    localparam logic [31:0] IPCL_FLAG_RESET = 32'h0000_0000;
    localparam logic [31:0] IPCL_ZERO_WORD  = 32'h0000_0000;
    localparam logic [1:0]  IPCL_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  IPCL_RESP_SLVERR = 2'h2;

    // ************************************************************
    // state types
    // ************************************************************
    typedef enum logic [0:0]
    {
        IPCL_WR_IDLE = 1'b0,
        IPCL_WR_RESP = 1'b1
    } ipcl_wr_state_t;

    typedef enum logic [0:0]
    {
        IPCL_RD_IDLE = 1'b0,
        IPCL_RD_DATA = 1'b1
    } ipcl_rd_state_t;

endpackage : ipcl_pkg

// >>> core/ipcl_wr_capture.sv
`timescale 1ns/1ps
// holds write address and write data independently until the pair is consumed
module ipcl_wr_capture
    import ipcl_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic [IPCL_ADDR_W-1:0] awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [IPCL_DATA_W-1:0] wdata,
    input  wire logic [IPCL_STRB_W-1:0] wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    input  wire logic                   consume,
    output logic                        req_valid,
    output logic [IPCL_ADDR_W-1:0]      req_addr,
    output logic [IPCL_DATA_W-1:0]      req_data,
    output logic [IPCL_STRB_W-1:0]      req_strb
);

    logic aw_full_reg;
    logic w_full_reg;

    assign awready   = ~aw_full_reg;
    assign wready    = ~w_full_reg;
    assign req_valid = aw_full_reg & w_full_reg;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_full_reg <= 1'b0;
            req_addr    <= '0;
        end
        else if (consume)
            aw_full_reg <= 1'b0;
        else if (awvalid && !aw_full_reg)
        begin
            aw_full_reg <= 1'b1;
            req_addr    <= awaddr;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            w_full_reg <= 1'b0;
            req_data   <= '0;
            req_strb   <= '0;
        end
        else if (consume)
            w_full_reg <= 1'b0;
        else if (wvalid && !w_full_reg)
        begin
            w_full_reg <= 1'b1;
            req_data   <= wdata;
            req_strb   <= wstrb;
        end
    end

endmodule : ipcl_wr_capture

// >>> core/ipcl_direction.sv
`timescale 1ns/1ps
// one event direction: shared flag register plus its interrupt lines
module ipcl_direction
    import ipcl_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire logic [IPCL_CHANNELS-1:0] set_bits,
    input  wire logic [IPCL_CHANNELS-1:0] ack_bits,
    output logic [IPCL_CHANNELS-1:0]      flag_reg,
    output logic [IPCL_IRQ_CHANS-1:0]     irq
);

    genvar ch;
    generate
        for (ch = 0; ch < IPCL_CHANNELS; ch++)
        begin : g_chan
            // set beats ack in the same cycle so no event is lost
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                    flag_reg[ch] <= IPCL_FLAG_RESET[ch];
                else if (set_bits[ch])
                    flag_reg[ch] <= 1'b1;
                else if (ack_bits[ch])
                    flag_reg[ch] <= 1'b0;
            end
        end
    endgenerate

    // interrupt straight from the flag flops, no extra latency
    assign irq = flag_reg[IPCL_IRQ_CHANS-1:0];

endmodule : ipcl_direction

// >>> core/ipcl_top.sv
// Overview of operation
// - two independent directions, master-to-control and control-to-master.
// - each direction has 32 channels; bit n of each register is channel n.
// - channels 0..3 drive an interrupt while their flag is set.
// - writing 1 to a set bit sets the matching flag bit.
// - writing 1 to an ack bit clears the matching flag bit.
// - channels 0..3 may use interrupts instead of polling; sequence unchanged.
// - control-to-master direction behaves the same with its own registers.
// - one flag register per direction, same bits in sender and receiver views.
`timescale 1ns/1ps
module ipcl_top
    import ipcl_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    input  wire logic [IPCL_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [IPCL_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [IPCL_STRB_W-1:0]    s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [IPCL_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [IPCL_DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    output logic [IPCL_IRQ_CHANS-1:0]      m2c_irq,
    output logic [IPCL_IRQ_CHANS-1:0]      c2m_irq
);

    // ************************************************************
    // signals
    // ************************************************************
    ipcl_wr_state_t               wr_state_reg;
    ipcl_wr_state_t               wr_state_next;
    ipcl_rd_state_t               rd_state_reg;
    logic                         req_valid;
    logic [IPCL_ADDR_W-1:0]       req_addr;
    logic [IPCL_DATA_W-1:0]       req_data;
    logic [IPCL_STRB_W-1:0]       req_strb;
    logic                         wr_fire;
    logic [IPCL_ADDR_W-1:0]       wr_ofs;
    logic [IPCL_ADDR_W-1:0]       rd_ofs;
    logic [IPCL_DATA_W-1:0]       wr_bits;
    logic [IPCL_CHANNELS-1:0]     m2c_set_bits;
    logic [IPCL_CHANNELS-1:0]     m2c_ack_bits;
    logic [IPCL_CHANNELS-1:0]     c2m_set_bits;
    logic [IPCL_CHANNELS-1:0]     c2m_ack_bits;
    logic [IPCL_CHANNELS-1:0]     m2c_flag;
    logic [IPCL_CHANNELS-1:0]     c2m_flag;
    logic [1:0]                   bresp_reg;
    logic [1:0]                   bresp_next;
    logic [IPCL_DATA_W-1:0]       rdata_reg;
    logic [IPCL_DATA_W-1:0]       rdata_next;
    logic [1:0]                   rresp_reg;
    logic [1:0]                   rresp_next;

    // ************************************************************
    // write channel capture
    // ************************************************************
    ipcl_wr_capture u_wr_capture
    (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .awaddr    (s_axi_awaddr),
        .awvalid   (s_axi_awvalid),
        .awready   (s_axi_awready),
        .wdata     (s_axi_wdata),
        .wstrb     (s_axi_wstrb),
        .wvalid    (s_axi_wvalid),
        .wready    (s_axi_wready),
        .consume   (wr_fire),
        .req_valid (req_valid),
        .req_addr  (req_addr),
        .req_data  (req_data),
        .req_strb  (req_strb)
    );

    // one write at a time: a new pair is consumed only when no response is pending
    assign wr_fire = (wr_state_reg == IPCL_WR_IDLE) && req_valid;
    // low address bits ignored, every register is one aligned word
    assign wr_ofs  = {req_addr[IPCL_ADDR_W-1:2], 2'b00};
    assign rd_ofs  = {s_axi_araddr[IPCL_ADDR_W-1:2], 2'b00};

    // byte enables gate which channels a write can touch
    always_comb
    begin
        wr_bits = IPCL_ZERO_WORD;
        for (int b = 0; b < IPCL_STRB_W; b++)
        begin
            if (req_strb[b])
                wr_bits[8*b +: 8] = req_data[8*b +: 8];
        end
    end

    // ************************************************************
    // write decode into set and ack pulses
    // ************************************************************
    always_comb
    begin
        m2c_set_bits = '0;
        m2c_ack_bits = '0;
        c2m_set_bits = '0;
        c2m_ack_bits = '0;
        bresp_next   = IPCL_RESP_OKAY;
        case (wr_ofs)
            IPCL_M2C_SET_OFS:
                m2c_set_bits = wr_fire ? wr_bits : '0;
            IPCL_M2C_ACK_OFS:
                m2c_ack_bits = wr_fire ? wr_bits : '0;
            IPCL_C2M_SET_OFS:
                c2m_set_bits = wr_fire ? wr_bits : '0;
            IPCL_C2M_ACK_OFS:
                c2m_ack_bits = wr_fire ? wr_bits : '0;
            // flag views are read only and the rest is unmapped
            default:
                bresp_next = IPCL_RESP_SLVERR;
        endcase
    end

    // ************************************************************
    // the two directions, fully separate
    // ************************************************************
    ipcl_direction u_m2c
    (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .set_bits (m2c_set_bits),
        .ack_bits (m2c_ack_bits),
        .flag_reg (m2c_flag),
        .irq      (m2c_irq)
    );

    ipcl_direction u_c2m
    (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .set_bits (c2m_set_bits),
        .ack_bits (c2m_ack_bits),
        .flag_reg (c2m_flag),
        .irq      (c2m_irq)
    );

    // ************************************************************
    // write response
    // ************************************************************
    always_comb
    begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            IPCL_WR_IDLE:
                if (req_valid)
                    wr_state_next = IPCL_WR_RESP;
            IPCL_WR_RESP:
                if (s_axi_bready)
                    wr_state_next = IPCL_WR_IDLE;
            default:
                wr_state_next = IPCL_WR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_state_reg <= IPCL_WR_IDLE;
            bresp_reg    <= IPCL_RESP_OKAY;
        end
        else
        begin
            wr_state_reg <= wr_state_next;
            if (wr_fire)
                bresp_reg <= bresp_next;
        end
    end

    assign s_axi_bvalid = (wr_state_reg == IPCL_WR_RESP);
    assign s_axi_bresp  = bresp_reg;

    // ************************************************************
    // read path
    // ************************************************************
    // both views of a direction return the very same flops
    always_comb
    begin
        rdata_next = IPCL_ZERO_WORD;
        rresp_next = IPCL_RESP_OKAY;
        case (rd_ofs)
            IPCL_M2C_FLAG_SND_OFS,
            IPCL_M2C_FLAG_RCV_OFS:
                rdata_next = m2c_flag;
            IPCL_C2M_FLAG_SND_OFS,
            IPCL_C2M_FLAG_RCV_OFS:
                rdata_next = c2m_flag;
            // write-only registers read as zero
            IPCL_M2C_SET_OFS,
            IPCL_M2C_ACK_OFS,
            IPCL_C2M_SET_OFS,
            IPCL_C2M_ACK_OFS:
                rdata_next = IPCL_ZERO_WORD;
            default:
                rresp_next = IPCL_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rd_state_reg <= IPCL_RD_IDLE;
        else
        begin
            case (rd_state_reg)
                IPCL_RD_IDLE:
                    if (s_axi_arvalid)
                        rd_state_reg <= IPCL_RD_DATA;
                IPCL_RD_DATA:
                    if (s_axi_rready)
                        rd_state_reg <= IPCL_RD_IDLE;
                default:
                    rd_state_reg <= IPCL_RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_reg <= IPCL_ZERO_WORD;
            rresp_reg <= IPCL_RESP_OKAY;
        end
        else if (rd_state_reg == IPCL_RD_IDLE && s_axi_arvalid)
        begin
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign s_axi_arready = (rd_state_reg == IPCL_RD_IDLE);
    assign s_axi_rvalid  = (rd_state_reg == IPCL_RD_DATA);
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // ************************************************************
    // checks
    // ************************************************************
    m2c_set_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (|m2c_set_bits) |=> ((m2c_flag & $past(m2c_set_bits)) == $past(m2c_set_bits)))
        else $error("m2c set did not raise its flags");

    m2c_ack_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (|m2c_ack_bits) |=> ((m2c_flag & $past(m2c_ack_bits)) == '0))
        else $error("m2c ack did not clear its flags");

    c2m_set_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (|c2m_set_bits) |=> ((c2m_flag & $past(c2m_set_bits)) == $past(c2m_set_bits)))
        else $error("c2m set did not raise its flags");

    untouched_hold_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        ##1 ((m2c_flag & ~$past(m2c_set_bits | m2c_ack_bits))
             == ($past(m2c_flag) & ~$past(m2c_set_bits | m2c_ack_bits))))
        else $error("unwritten m2c flag bits changed");

    dir_independent_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (|{m2c_set_bits, m2c_ack_bits}) |=> $stable(c2m_flag))
        else $error("m2c write disturbed c2m flags");

    irq_follows_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (|m2c_set_bits[IPCL_IRQ_CHANS-1:0])
        |=> (m2c_irq == m2c_flag[IPCL_IRQ_CHANS-1:0]) && (|m2c_irq))
        else $error("interrupt does not follow flag");

    views_match_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (s_axi_arready && s_axi_arvalid && rd_ofs == IPCL_C2M_FLAG_RCV_OFS)
        |=> s_axi_rvalid && (s_axi_rdata == $past(c2m_flag)))
        else $error("status view differs from flag");

    reset_clear_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        $rose(resetn) |-> (m2c_flag == '0) && (c2m_flag == '0) && (c2m_irq == '0))
        else $error("flags not clear after reset");

    bresp_hold_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before bready");

    c2m_ack_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (|c2m_ack_bits) |=> ((c2m_flag & $past(c2m_ack_bits)) == '0))
        else $error("c2m ack did not clear its flags");

    c2m_untouched_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        ##1 ((c2m_flag & ~$past(c2m_set_bits | c2m_ack_bits))
             == ($past(c2m_flag) & ~$past(c2m_set_bits | c2m_ack_bits))))
        else $error("unwritten c2m flag bits changed");

    m2c_irq_drop_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (|m2c_ack_bits[IPCL_IRQ_CHANS-1:0])
        |=> ((m2c_irq & $past(m2c_ack_bits[IPCL_IRQ_CHANS-1:0])) == '0))
        else $error("m2c interrupt stayed up after ack");

    c2m_irq_drop_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (|c2m_ack_bits[IPCL_IRQ_CHANS-1:0])
        |=> ((c2m_irq & $past(c2m_ack_bits[IPCL_IRQ_CHANS-1:0])) == '0))
        else $error("c2m interrupt stayed up after ack");

    ro_view_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (wr_fire && (wr_ofs == IPCL_M2C_FLAG_RCV_OFS || wr_ofs == IPCL_C2M_FLAG_RCV_OFS))
        |=> $stable(m2c_flag) && $stable(c2m_flag))
        else $error("write to a flag view changed flags");

    bvalid_after_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        wr_fire |=> s_axi_bvalid)
        else $error("no write response after a consumed write");

endmodule : ipcl_top

// >>> testbench/ipcl_core_model.sv
`timescale 1ns/1ps
// ************************************************************
// control-side core model: answers the event interrupts
// ************************************************************
module ipcl_core_model
    import ipcl_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    input  wire logic [IPCL_IRQ_CHANS-1:0] irq_in,
    input  wire logic [IPCL_DATA_W-1:0]    msg_word,
    output logic [7:0]                     event_count,
    output logic [IPCL_DATA_W-1:0]         got_msg
);
    logic [IPCL_IRQ_CHANS-1:0] irq_seen_reg;

    // interrupt used in place of polling; one count per cycle in which any line rises
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_seen_reg <= 4'h0;
            event_count  <= 8'h00;
        end
        else
        begin
            irq_seen_reg <= irq_in;
            if ((irq_in & ~irq_seen_reg) != 4'h0)
            begin
                event_count <= event_count + 8'h01;
            end
        end
    end

    // message read on channel 0 event, before the bench acknowledges
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            got_msg <= 32'h0000_0000;
        end
        else if (irq_in[0] && !irq_seen_reg[0])
        begin
            got_msg <= msg_word;
        end
    end
endmodule : ipcl_core_model

// >>> testbench/test_ipcl_top.sv
`timescale 1ns/1ps
module test_ipcl_top
    import ipcl_pkg::*;
;
    localparam int TIMEOUT_CYCLES = 20000;
    logic                   clk_sys, resetn;
    logic [IPCL_ADDR_W-1:0] awaddr, araddr;
    logic                   awvalid, wvalid, bready, arvalid, rready;
    logic [IPCL_DATA_W-1:0] wdata, rdata, msg_word, got_msg;
    logic [IPCL_STRB_W-1:0] wstrb;
    logic                   awready, wready, bvalid, arready, rvalid;
    logic [1:0]             bresp, rresp;
    logic [3:0]             m2c_irq, c2m_irq;
    logic [7:0]             event_count;
    int                     miscompares, tests_run, cycles, b_hold;

    ipcl_top ipcl_top_i (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .m2c_irq(m2c_irq), .c2m_irq(c2m_irq));

    ipcl_core_model ipcl_core_model_i (.clk_sys(clk_sys), .resetn(resetn), .irq_in(m2c_irq),
        .msg_word(msg_word), .event_count(event_count), .got_msg(got_msg));

    // ************************************************************
    // clock and hang guard
    // ************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES)
        begin
            miscompares++;
            give_verdict();
        end
    end

    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // holds each channel until taken; response waited for with no bound of its own
    task automatic write_expect(input logic [7:0] addr, input logic [31:0] data,
                                input logic [3:0] strb, input logic [1:0] exp_resp);
        int   n;
        logic aw_done, w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= addr;
        awvalid <= 1'b1;
        wdata <= data;
        wstrb <= strb;
        wvalid <= 1'b1;
        bready <= (b_hold == 0);
        do
        begin
            @(posedge clk_sys);
            if (!aw_done && awready)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            n++;
            if (n == b_hold)
                bready <= 1'b1;
        end while (!(bvalid && bready && aw_done && w_done));
        check("write response", {30'h0000_0000, bresp}, {30'h0000_0000, exp_resp});
        bready <= 1'b0;
        @(posedge clk_sys);
    endtask : write_expect

    task automatic read_expect(input logic [7:0] addr, input logic [31:0] exp,
                               input logic [1:0] exp_resp);
        int   n;
        logic ar_done;
        n = 0;
        ar_done = 1'b0;
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (!ar_done && arready)
            begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
            n++;
        end while (!(rvalid && ar_done));
        check("read data", rdata, exp);
        check("read response", {30'h0000_0000, rresp}, {30'h0000_0000, exp_resp});
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask : read_expect

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_reset_clear();
        write_expect(IPCL_M2C_SET_OFS, 32'h8000_000F, 4'hF, IPCL_RESP_OKAY);
        write_expect(IPCL_C2M_SET_OFS, 32'h0001_0003, 4'hF, IPCL_RESP_OKAY);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("irq during reset", {24'h00_0000, m2c_irq, c2m_irq}, 32'h0000_0000);
        resetn <= 1'b1;
        @(posedge clk_sys);
        read_expect(IPCL_M2C_FLAG_SND_OFS, IPCL_FLAG_RESET, IPCL_RESP_OKAY);
        read_expect(IPCL_C2M_FLAG_RCV_OFS, IPCL_FLAG_RESET, IPCL_RESP_OKAY);
    endtask : test_reset_clear

    task automatic test_handshake();
        read_expect(IPCL_M2C_FLAG_SND_OFS, 32'h0000_0000, IPCL_RESP_OKAY);
        write_expect(IPCL_M2C_SET_OFS, 32'h0000_0004, 4'hF, IPCL_RESP_OKAY);
        read_expect(IPCL_M2C_FLAG_RCV_OFS, 32'h0000_0004, IPCL_RESP_OKAY);
        read_expect(IPCL_M2C_FLAG_SND_OFS, 32'h0000_0004, IPCL_RESP_OKAY);
        check("m2c irq", {28'h000_0000, m2c_irq}, 32'h0000_0004);
        check("c2m irq", {28'h000_0000, c2m_irq}, 32'h0000_0000);
        read_expect(IPCL_C2M_FLAG_SND_OFS, 32'h0000_0000, IPCL_RESP_OKAY);
        write_expect(IPCL_M2C_ACK_OFS, 32'h0000_0004, 4'hF, IPCL_RESP_OKAY);
        read_expect(IPCL_M2C_FLAG_RCV_OFS, 32'h0000_0000, IPCL_RESP_OKAY);
        check("m2c irq after ack", {28'h000_0000, m2c_irq}, 32'h0000_0000);
    endtask : test_handshake

    // every channel of the return direction, one bit at a time
    task automatic test_channels();
        logic [31:0] mask;
        mask = 32'h0000_0000;
        for (int n = 0; n < IPCL_CHANNELS; n++)
        begin
            mask = mask | (32'h0000_0001 << n);
            write_expect(IPCL_C2M_SET_OFS, 32'h0000_0001 << n, 4'hF, IPCL_RESP_OKAY);
            read_expect(IPCL_C2M_FLAG_RCV_OFS, mask, IPCL_RESP_OKAY);
            check("c2m irq", {28'h000_0000, c2m_irq}, {28'h000_0000, mask[3:0]});
        end
        write_expect(IPCL_C2M_ACK_OFS, 32'hAAAA_AAAA, 4'hF, IPCL_RESP_OKAY);
        read_expect(IPCL_C2M_FLAG_SND_OFS, 32'h5555_5555, IPCL_RESP_OKAY);
        write_expect(IPCL_C2M_SET_OFS, 32'h0000_0000, 4'hF, IPCL_RESP_OKAY);
        write_expect(IPCL_C2M_ACK_OFS, 32'h0000_0000, 4'hF, IPCL_RESP_OKAY);
        read_expect(IPCL_C2M_FLAG_RCV_OFS, 32'h5555_5555, IPCL_RESP_OKAY);
        read_expect(IPCL_M2C_FLAG_RCV_OFS, 32'h0000_0000, IPCL_RESP_OKAY);
        write_expect(IPCL_C2M_ACK_OFS, 32'hFFFF_FFFF, 4'hF, IPCL_RESP_OKAY);
        read_expect(IPCL_C2M_FLAG_SND_OFS, 32'h0000_0000, IPCL_RESP_OKAY);
    endtask : test_channels

    // disabled byte lanes and read-only or unmapped places
    task automatic test_bus_edges();
        // late bready: the response must stand until it is taken
        b_hold = 4;
        write_expect(IPCL_M2C_SET_OFS, 32'hFFFF_FFFF, 4'h2, IPCL_RESP_OKAY);
        b_hold = 0;
        read_expect(IPCL_M2C_FLAG_SND_OFS, 32'h0000_FF00, IPCL_RESP_OKAY);
        write_expect(IPCL_M2C_FLAG_RCV_OFS, 32'h0000_0000, 4'hF, IPCL_RESP_SLVERR);
        read_expect(IPCL_M2C_FLAG_SND_OFS, 32'h0000_FF00, IPCL_RESP_OKAY);
        write_expect(8'h20, 32'hFFFF_FFFF, 4'hF, IPCL_RESP_SLVERR);
        read_expect(8'h20, IPCL_ZERO_WORD, IPCL_RESP_SLVERR);
        read_expect(IPCL_M2C_SET_OFS, IPCL_ZERO_WORD, IPCL_RESP_OKAY);
        read_expect(IPCL_C2M_ACK_OFS, IPCL_ZERO_WORD, IPCL_RESP_OKAY);
        write_expect(IPCL_M2C_ACK_OFS, 32'h0000_FF00, 4'hF, IPCL_RESP_OKAY);
        read_expect(IPCL_M2C_FLAG_RCV_OFS, 32'h0000_0000, IPCL_RESP_OKAY);
    endtask : test_bus_edges

    // data passed with an event: message first, then the set bit
    task automatic test_message();
        logic [7:0] count_before;
        int         n;
        count_before = event_count;
        msg_word <= 32'hC0DE_5A17;
        write_expect(IPCL_M2C_SET_OFS, 32'h0000_0001, 4'hF, IPCL_RESP_OKAY);
        n = 0;
        while (event_count == count_before && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        check("events seen", {24'h00_0000, event_count}, {24'h00_0000, count_before + 8'h01});
        check("message taken", got_msg, 32'hC0DE_5A17);
        write_expect(IPCL_M2C_ACK_OFS, 32'h0000_0001, 4'hF, IPCL_RESP_OKAY);
        check("irq released", {28'h000_0000, m2c_irq}, 32'h0000_0000);
    endtask : test_message

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        miscompares = 0;
        tests_run = 0;
        cycles = 0;
        b_hold = 0;
        resetn = 1'b0;
        {awaddr, araddr, wdata, msg_word} = '0;
        {awvalid, wvalid, bready, arvalid, rready, wstrb} = '0;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        check("irq after reset", {24'h00_0000, m2c_irq, c2m_irq}, 32'h0000_0000);
        test_handshake();
        test_channels();
        test_bus_edges();
        test_message();
        test_reset_clear();
        give_verdict();
    end
endmodule : test_ipcl_top
